// File: rtl/wspc_consts.vh
`ifndef WSPC_CONSTS_VH
`define WSPC_CONSTS_VH

// ----------------------------------------------------------------
// Context codes
// ----------------------------------------------------------------
`define WSPC_CTX_W 2
`define WSPC_CTX_MAIN 2'h0
`define WSPC_CTX_IRQ 2'h1
`define WSPC_CTX_NMI 2'h2

// ----------------------------------------------------------------
// Resume actions
// ----------------------------------------------------------------
`define WSPC_ACT_W 2
`define WSPC_ACT_NONE 2'h0
`define WSPC_ACT_NEXT 2'h1
`define WSPC_ACT_IRQ 2'h2
`define WSPC_ACT_NMI 2'h3

// ----------------------------------------------------------------
// Oscillator settle wait
// ----------------------------------------------------------------
`define WSPC_SETTLE_W 16
`define WSPC_SETTLE_DEF 16'h0400
`define WSPC_CNT_ONE 16'h0001
`define WSPC_CNT_ZERO 16'h0000

`endif

// File: rtl/wspc_power_seq.v
// Notes on behaviour
// RULE1: Wait instruction freezes core, peripherals run.
// RULE2: Oscillator stays on during wait.
// RULE3: Pin or watchdog reset in wait resets.
// RULE4: Wait wake by interrupt: no settle delay.
// RULE5: Active watchdog turns stop into wait.
// RULE6: Stop halts oscillator until interrupt or reset; code wakes stop only on external or NMI requests or the reset pin.
// RULE7: Memory and registers kept in low power.
// RULE8: Reset pin during stop starts reset.
// RULE9: Stop wake inserts oscillator settle wait.
// RULE10: Wake leaves oscillator selection unchanged.
// RULE11: Main context: service routine first, then next.
// RULE12: NMI context: continue next, stay NMI.
// RULE13: IRQ context, IRQ wake: continue routine.
// RULE14: IRQ context, NMI wake: NMI then resume.
// RULE15: Global enable clear: only reset wakes.
// RULE16: Pending enabled request: low-power instruction ignored.
// RULE17: Software powers down peripherals before stop.
// RULE18: Global enable gates maskable, NMI stays.
// RULE19: Settle wait is a parameter clock count.
`include "wspc_consts.vh"
`timescale 1ns/1ps

module wspc_power_seq #(
    parameter [`WSPC_SETTLE_W-1:0] SETTLE_CYCLES = `WSPC_SETTLE_DEF
) (
    // Clock, reset, enable
    input wire CORE_CLK_I,
    input wire RESETN_I,
    input wire CLK_EN_I,
    // Core requests (same clock)
    input wire WAIT_EXEC_I,
    input wire STOP_EXEC_I,
    input wire IN_IRQ_CTX_I,
    input wire IN_NMI_CTX_I,
    input wire GLOBAL_INTERRUPT_ENABLE_I,
    // Wake sources from pins and peripherals (asynchronous)
    input wire NMI_REQ_I,
    input wire IRQ_REQ_I,
    input wire EXT_IRQ_REQ_I,
    input wire RESET_PIN_N_I,
    input wire WDOG_RESET_I,
    input wire WDOG_ACTIVE_I,
    // Outputs to core and clock tree
    output reg CORE_HOLD_O,
    output reg OSC_RUN_O,
    output reg PERIPH_CLK_EN_O,
    output reg SYS_RESET_REQ_O,
    output reg RESUME_PULSE_O,
    output reg [`WSPC_ACT_W-1:0] RESUME_ACT_O,
    output reg WAIT_STATE_O,
    output reg STOP_STATE_O
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam [3:0] ST_RUN = 4'h1;
localparam [3:0] ST_WAIT = 4'h2;
localparam [3:0] ST_STOP = 4'h4;
localparam [3:0] ST_SETTLE = 4'h8;

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
localparam NSYNC = 6;
wire [NSYNC-1:0] async_in;
reg [NSYNC-1:0] sync1_q;
reg [NSYNC-1:0] sync2_q;
assign async_in = {WDOG_ACTIVE_I, WDOG_RESET_I, ~RESET_PIN_N_I,
                   EXT_IRQ_REQ_I, IRQ_REQ_I, NMI_REQ_I};

genvar gi;
generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
        // Two-stage synchroniser per input
        always @(posedge CORE_CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
                sync1_q[gi] <= 1'b0;
                sync2_q[gi] <= 1'b0;
            end else if (CLK_EN_I) begin
                sync1_q[gi] <= async_in[gi];
                sync2_q[gi] <= sync1_q[gi];
            end
        end
    end
endgenerate

wire nmi_s = sync2_q[0];
wire irq_s = sync2_q[1];
wire ext_s = sync2_q[2];
wire pin_rst_s = sync2_q[3];
wire wdog_rst_s = sync2_q[4];
wire wdog_act_s = sync2_q[5];

// ----------------------------------------------------------------
// Wake qualification
// ----------------------------------------------------------------
// Maskable requests gated by global enable, NMI always pending
wire irq_en = GLOBAL_INTERRUPT_ENABLE_I & (irq_s | ext_s); // RULE18
wire pending = irq_en | nmi_s; // RULE18
// No wake at all while global enable is clear
wire wake_wait = GLOBAL_INTERRUPT_ENABLE_I & (irq_s | ext_s | nmi_s); // RULE15
// Stop only woken by external or NMI pin requests
wire wake_stop = GLOBAL_INTERRUPT_ENABLE_I & (ext_s | nmi_s); // RULE15 RULE6
wire ld_pend = GLOBAL_INTERRUPT_ENABLE_I & nmi_s;

// ----------------------------------------------------------------
// State, context and settle counter
// ----------------------------------------------------------------
reg [3:0] state_q;
reg [3:0] state_d;
reg [`WSPC_CTX_W-1:0] ctx_q;
reg [`WSPC_CTX_W-1:0] ctx_d;
reg nmi_wake_q;
reg nmi_wake_d;
reg [`WSPC_SETTLE_W-1:0] cnt_q;
reg [`WSPC_SETTLE_W-1:0] cnt_d;
reg [`WSPC_ACT_W-1:0] act_d;
reg res_d;

// Resume action from saved context and wake kind
function [`WSPC_ACT_W-1:0] pick_act;
    input [`WSPC_CTX_W-1:0] ctx;
    input by_nmi;
    begin
        case (ctx)
            `WSPC_CTX_MAIN: pick_act = by_nmi ? `WSPC_ACT_NMI : `WSPC_ACT_IRQ; // RULE11
            `WSPC_CTX_NMI: pick_act = `WSPC_ACT_NEXT; // RULE12
            `WSPC_CTX_IRQ: pick_act = by_nmi ? `WSPC_ACT_NMI : `WSPC_ACT_NEXT; // RULE13 RULE14
            default: pick_act = `WSPC_ACT_NEXT;
        endcase
    end
endfunction

wire [`WSPC_CTX_W-1:0] cur_ctx = IN_NMI_CTX_I ? `WSPC_CTX_NMI :
                                 (IN_IRQ_CTX_I ? `WSPC_CTX_IRQ : `WSPC_CTX_MAIN);
wire any_rst = pin_rst_s | wdog_rst_s;

// Next-state logic
always @* begin
    state_d = state_q;
    ctx_d = ctx_q;
    nmi_wake_d = nmi_wake_q;
    cnt_d = cnt_q;
    act_d = `WSPC_ACT_NONE;
    res_d = 1'b0;
    case (state_q)
        ST_RUN: begin
            // Instructions dropped while an enabled request pends
            if ((WAIT_EXEC_I | STOP_EXEC_I) & ~pending) begin // RULE16
                ctx_d = cur_ctx;
                if (WAIT_EXEC_I | wdog_act_s) begin // RULE5
                    state_d = ST_WAIT; // RULE1
                end else begin
                    state_d = ST_STOP; // RULE6
                end
            end
        end
        ST_WAIT: begin
            if (any_rst) begin
                state_d = ST_RUN; // RULE3
            end else if (wake_wait) begin
                // Clock never stopped, resume at once
                state_d = ST_RUN; // RULE4
                res_d = 1'b1;
                act_d = pick_act(ctx_q, ld_pend);
            end
        end
        ST_STOP: begin
            if (pin_rst_s) begin
                state_d = ST_RUN; // RULE8
            end else if (wake_stop) begin
                state_d = ST_SETTLE; // RULE9
                nmi_wake_d = ld_pend;
                cnt_d = SETTLE_CYCLES; // RULE19
            end
        end
        ST_SETTLE: begin
            if (pin_rst_s) begin
                state_d = ST_RUN; // RULE8
            end else if (cnt_q <= `WSPC_CNT_ONE) begin
                state_d = ST_RUN; // RULE9
                res_d = 1'b1;
                act_d = pick_act(ctx_q, nmi_wake_q);
                cnt_d = `WSPC_CNT_ZERO;
            end else begin
                cnt_d = cnt_q - `WSPC_CNT_ONE; // RULE19
            end
        end
        default: begin
            state_d = ST_RUN;
        end
    endcase
end

// State registers; oscillator selection is never touched here
always @(posedge CORE_CLK_I or negedge RESETN_I) begin // RULE10
    if (!RESETN_I) begin
        state_q <= ST_RUN;
        ctx_q <= `WSPC_CTX_MAIN;
        nmi_wake_q <= 1'b0;
        cnt_q <= `WSPC_CNT_ZERO;
    end else if (CLK_EN_I) begin
        state_q <= state_d;
        ctx_q <= ctx_d;
        nmi_wake_q <= nmi_wake_d;
        cnt_q <= cnt_d;
    end
end

// ----------------------------------------------------------------
// Registered outputs
// ----------------------------------------------------------------
// Retention: no state cleared on low-power entry, supplies untouched
always @(posedge CORE_CLK_I or negedge RESETN_I) begin // RULE7
    if (!RESETN_I) begin
        CORE_HOLD_O <= 1'b0;
        OSC_RUN_O <= 1'b1;
        PERIPH_CLK_EN_O <= 1'b1;
        SYS_RESET_REQ_O <= 1'b0;
        RESUME_PULSE_O <= 1'b0;
        RESUME_ACT_O <= `WSPC_ACT_NONE;
        WAIT_STATE_O <= 1'b0;
        STOP_STATE_O <= 1'b0;
    end else if (CLK_EN_I) begin
        CORE_HOLD_O <= (state_d != ST_RUN); // RULE1
        OSC_RUN_O <= (state_d != ST_STOP); // RULE2 RULE6
        PERIPH_CLK_EN_O <= (state_d != ST_STOP) & (state_d != ST_SETTLE); // RULE2
        SYS_RESET_REQ_O <= ((state_q == ST_WAIT) & any_rst) |
                           (((state_q == ST_STOP) | (state_q == ST_SETTLE)) & pin_rst_s); // RULE3 RULE8
        RESUME_PULSE_O <= res_d;
        RESUME_ACT_O <= act_d;
        WAIT_STATE_O <= (state_d == ST_WAIT);
        STOP_STATE_O <= (state_d == ST_STOP) | (state_d == ST_SETTLE);
    end
end

endmodule // wspc_power_seq

// File: verification/wspc_power_seq_monitor.sv
`timescale 1ns/1ps
`include "wspc_consts.vh"
// ------------------------------------------------------------
// Port checker for the power sequencer
// ------------------------------------------------------------
module wspc_power_seq_monitor #(parameter int SETTLE = 4) (
    input wire CORE_CLK_I, RESETN_I, WAIT_EXEC_I, STOP_EXEC_I, IN_NMI_CTX_I,
    input wire GLOBAL_INTERRUPT_ENABLE_I, IRQ_REQ_I, RESET_PIN_N_I, WDOG_RESET_I,
    input wire WDOG_ACTIVE_I, CORE_HOLD_O, OSC_RUN_O, PERIPH_CLK_EN_O, SYS_RESET_REQ_O,
    input wire RESUME_PULSE_O, WAIT_STATE_O, STOP_STATE_O,
    input wire [`WSPC_ACT_W-1:0] RESUME_ACT_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);
    // State, clock and wake relations
    a_wait_frozen: assert property (WAIT_STATE_O |-> CORE_HOLD_O && OSC_RUN_O && PERIPH_CLK_EN_O)
        else $error("wait state outputs wrong");
    a_stop_osc_off: assert property ($rose(STOP_STATE_O) |-> !OSC_RUN_O && !PERIPH_CLK_EN_O)
        else $error("oscillator not halted in stop");
    a_wake_free: assert property (RESUME_PULSE_O |-> !CORE_HOLD_O && !WAIT_STATE_O && OSC_RUN_O)
        else $error("resume while still held");
    a_nmi_next: assert property (RESUME_PULSE_O && IN_NMI_CTX_I |-> RESUME_ACT_O == `WSPC_ACT_NEXT)
        else $error("nmi context resume action wrong");
    a_gie_wake: assert property (RESUME_PULSE_O |-> $past(GLOBAL_INTERRUPT_ENABLE_I))
        else $error("wake with global enable clear");
    a_stop_wdog: assert property ($rose(STOP_STATE_O) |-> !$past(WDOG_ACTIVE_I))
        else $error("stop entered with watchdog active");
    a_pend_skip: assert property ((WAIT_EXEC_I || STOP_EXEC_I) && GLOBAL_INTERRUPT_ENABLE_I
        && IRQ_REQ_I && $past(IRQ_REQ_I, 2) && !CORE_HOLD_O |=> !CORE_HOLD_O)
        else $error("low power entered while pending");
    a_settle_len: assert property ($rose(OSC_RUN_O) && RESET_PIN_N_I |-> ##SETTLE RESUME_PULSE_O)
        else $error("settle wait length wrong");
    a_rst_wait: assert property (WAIT_STATE_O && (WDOG_RESET_I || !RESET_PIN_N_I) |-> ##[1:4] SYS_RESET_REQ_O)
        else $error("no reset request from wait");
    a_rst_stop: assert property (STOP_STATE_O && !RESET_PIN_N_I |-> ##[1:4] SYS_RESET_REQ_O)
        else $error("no reset request from stop");
endmodule // wspc_power_seq_monitor

bind wspc_power_seq wspc_power_seq_monitor #(.SETTLE(SETTLE_CYCLES)) u_mon (.CORE_CLK_I,
    .RESETN_I, .WAIT_EXEC_I, .STOP_EXEC_I, .IN_NMI_CTX_I, .GLOBAL_INTERRUPT_ENABLE_I, .IRQ_REQ_I,
    .RESET_PIN_N_I, .WDOG_RESET_I, .WDOG_ACTIVE_I, .CORE_HOLD_O, .OSC_RUN_O, .PERIPH_CLK_EN_O,
    .SYS_RESET_REQ_O, .RESUME_PULSE_O, .WAIT_STATE_O, .STOP_STATE_O, .RESUME_ACT_O);

// File: verification/wspc_core_model.sv
`timescale 1ns/1ps
// Core model: requests registered as exec signals while the core is not held
module wspc_core_model (
    input wire logic clk_i, rst_n_i, hold_i, wait_req_i, stop_req_i,
    output logic wait_exec_o, stop_exec_o
);
    // Frozen core issues nothing; stop issued like wait, with no peripheral power-down check
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_exec_o <= 1'h0;
            stop_exec_o <= 1'h0;
        end else begin
            wait_exec_o <= wait_req_i && !hold_i;
            stop_exec_o <= stop_req_i && !hold_i;
        end
    end
endmodule // wspc_core_model

// File: verification/test_wait_stop_power_control.sv
`timescale 1ns/1ps
`include "wspc_consts.vh"
module test_wait_stop_power_control;
    logic CORE_CLK_I = 0, RESETN_I = 0, CLK_EN_I = 1, IN_IRQ_CTX_I = 0, IN_NMI_CTX_I = 0;
    logic GLOBAL_INTERRUPT_ENABLE_I = 1, NMI_REQ_I = 0, IRQ_REQ_I = 0, EXT_IRQ_REQ_I = 0;
    logic RESET_PIN_N_I = 1, WDOG_RESET_I = 0, WDOG_ACTIVE_I = 0, wr = 0, sr = 0;
    wire WAIT_EXEC_I, STOP_EXEC_I, CORE_HOLD_O, OSC_RUN_O, PERIPH_CLK_EN_O, SYS_RESET_REQ_O;
    wire RESUME_PULSE_O, WAIT_STATE_O, STOP_STATE_O;
    wire [`WSPC_ACT_W-1:0] RESUME_ACT_O;
    int err_count = 0, checked = 0, n;
    localparam int SET = 4;
    wspc_power_seq #(.SETTLE_CYCLES(16'h0004)) DUT (.CORE_CLK_I, .RESETN_I, .CLK_EN_I,
        .WAIT_EXEC_I, .STOP_EXEC_I, .IN_IRQ_CTX_I, .IN_NMI_CTX_I, .GLOBAL_INTERRUPT_ENABLE_I,
        .NMI_REQ_I, .IRQ_REQ_I, .EXT_IRQ_REQ_I, .RESET_PIN_N_I, .WDOG_RESET_I, .WDOG_ACTIVE_I,
        .CORE_HOLD_O, .OSC_RUN_O, .PERIPH_CLK_EN_O, .SYS_RESET_REQ_O, .RESUME_PULSE_O,
        .RESUME_ACT_O, .WAIT_STATE_O, .STOP_STATE_O);
    wspc_core_model CORE (.clk_i(CORE_CLK_I), .rst_n_i(RESETN_I), .hold_i(CORE_HOLD_O),
        .wait_req_i(wr), .stop_req_i(sr), .wait_exec_o(WAIT_EXEC_I), .stop_exec_o(STOP_EXEC_I));
    // Clock and watchdog
    initial forever #5 CORE_CLK_I = ~CORE_CLK_I;
    initial begin
        #50000;
        err_count++;
        print_verdict;
    end
    task print_verdict;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge CORE_CLK_I);
    endtask
    // Issue one instruction, sample one cycle after it is taken
    task go(input logic w, input logic s);
        tick(1);
        wr <= w;
        sr <= s;
        tick(1);
        wr <= 0;
        sr <= 0;
        tick(1);
        #1;
    endtask
    // Count edges to the resume pulse, check its action
    task wake(input int exp_n, input logic [1:0] act);
        n = 0;
        do begin
            tick(1);
            #1;
            n++;
        end while (RESUME_PULSE_O !== 1'h1 && n < 40);
        chk(n, exp_n);
        chk(RESUME_ACT_O, act);
        tick(1);
    endtask
    task do_rst;
        tick(1);
        RESETN_I <= 0;
        RESET_PIN_N_I <= 1;
        WDOG_RESET_I <= 0;
        NMI_REQ_I <= 0;
        GLOBAL_INTERRUPT_ENABLE_I <= 1;
        tick(5);
        RESETN_I <= 1;
        tick(3);
    endtask
    task t_wait_main;
        go(1, 0);
        chk({CORE_HOLD_O, WAIT_STATE_O, OSC_RUN_O, PERIPH_CLK_EN_O}, 8'h0F);
        tick(1);
        IRQ_REQ_I <= 1;
        wake(3, `WSPC_ACT_IRQ);
        IRQ_REQ_I <= 0;
    endtask
    // Main context: NMI wake runs NMI first; IRQ alone never wakes stop
    task t_main_nmi;
        go(1, 0);
        tick(1);
        NMI_REQ_I <= 1;
        wake(3, `WSPC_ACT_NMI);
        NMI_REQ_I <= 0;
        go(0, 1);
        IRQ_REQ_I <= 1;
        tick(6);
        #1;
        chk({STOP_STATE_O, OSC_RUN_O}, 8'h02);
        tick(1);
        EXT_IRQ_REQ_I <= 1;
        wake(3 + SET, `WSPC_ACT_IRQ);
        EXT_IRQ_REQ_I <= 0;
        IRQ_REQ_I <= 0;
    endtask
    task t_stop_nmi;
        tick(1);
        IN_NMI_CTX_I <= 1;
        go(0, 1);
        chk({OSC_RUN_O, PERIPH_CLK_EN_O, STOP_STATE_O}, 8'h01);
        tick(1);
        EXT_IRQ_REQ_I <= 1;
        wake(3 + SET, `WSPC_ACT_NEXT);
        EXT_IRQ_REQ_I <= 0;
        IN_NMI_CTX_I <= 0;
    endtask
    task t_wdog_irq;
        tick(1);
        WDOG_ACTIVE_I <= 1;
        IN_IRQ_CTX_I <= 1;
        go(0, 1);
        chk({WAIT_STATE_O, STOP_STATE_O, OSC_RUN_O}, 8'h05);
        tick(1);
        NMI_REQ_I <= 1;
        wake(3, `WSPC_ACT_NMI);
        NMI_REQ_I <= 0;
        go(1, 0);
        tick(1);
        IRQ_REQ_I <= 1;
        wake(3, `WSPC_ACT_NEXT);
        IRQ_REQ_I <= 0;
        IN_IRQ_CTX_I <= 0;
        WDOG_ACTIVE_I <= 0;
    endtask
    task t_pend;
        tick(1);
        IRQ_REQ_I <= 1;
        go(1, 0);
        chk({CORE_HOLD_O, WAIT_STATE_O}, 8'h00);
        go(0, 1);
        chk({CORE_HOLD_O, STOP_STATE_O}, 8'h00);
        tick(1);
        IRQ_REQ_I <= 0;
    endtask
    task t_gie_rst;
        tick(1);
        GLOBAL_INTERRUPT_ENABLE_I <= 0;
        go(1, 0);
        tick(1);
        NMI_REQ_I <= 1;
        tick(11);
        #1;
        chk({CORE_HOLD_O, WAIT_STATE_O}, 8'h03);
        tick(1);
        WDOG_RESET_I <= 1;
        tick(3);
        #1;
        chk(SYS_RESET_REQ_O, 8'h01);
        do_rst;
        go(0, 1);
        tick(1);
        RESET_PIN_N_I <= 0;
        tick(3);
        #1;
        chk(SYS_RESET_REQ_O, 8'h01);
        do_rst;
    endtask
    // Main sequence
    initial begin
        do_rst;
        t_wait_main;
        t_main_nmi;
        t_stop_nmi;
        t_wdog_irq;
        t_pend;
        t_gie_rst;
        print_verdict;
    end
endmodule // test_wait_stop_power_control
